// [rtl/tcm_port_pkg.sv]
/*
  Constants and types for the local memory master port.
  Assumes a single processor clock and word-wide local memory banks.
*/
package tcm_port_pkg;
  localparam int  IMEM_ADDR_HI  = 23;
  localparam int  IMEM_ADDR_LO  = 2;
  localparam int  DMEM_ADDR_HI  = 23;
  localparam int  DMEM_ADDR_LO  = 4;
  localparam int  DATA_BITS     = 32;
  localparam int  ECC_BITS      = 7;
  localparam int  WORD_BITS     = DATA_BITS + ECC_BITS;
  localparam int  STROBE_BITS   = 5;
  localparam int  ECC_STROBE    = 4;
  localparam int  DMEM_PORTS    = 4;
  localparam logic [4:0] STROBE_NONE = 5'h00;
  localparam logic [3:0] REQ_IFETCH     = 4'h0;
  localparam logic [3:0] REQ_SW_READ    = 4'h1;
  localparam logic [3:0] REQ_VECTOR     = 4'h2;
  localparam logic [3:0] REQ_SLAVE_RD   = 4'h3;
  localparam logic [3:0] REQ_DEBUG_RD   = 4'h4;
  localparam logic [3:0] REQ_SELF_TEST  = 4'h5;
  localparam logic [3:0] REQ_SW_WRITE   = 4'h9;
  localparam logic [3:0] REQ_DEBUG_WR   = 4'hB;
  localparam logic [3:0] REQ_ECC_FIX    = 4'hC;
  localparam logic [3:0] REQ_INIT_SP    = 4'hD;
  localparam logic [3:0] REQ_SLAVE_WR   = 4'hE;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RESP = 2'h1
  } phase_type;
endpackage

// [rtl/tightly_coupled_memory_port.sv]
/*
  Master port toward one instruction local memory and four data local memories.
  Assumes the user side holds a request until it is accepted and that the
  memories answer with stall, read word and fault on the processor clock.
*/
`timescale 1ns/1ps

module tightly_coupled_memory_port #(
  parameter int NPORT = tcm_port_pkg::DMEM_PORTS
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  // Instruction user side
  input  wire logic                 ireq_valid,
  input  wire logic [23:0]          ireq_addr,
  input  wire logic                 ireq_priv,
  input  wire logic                 ireq_write,
  input  wire logic [4:0]           ireq_strobe,
  input  wire logic [38:0]          ireq_wdata,
  input  wire logic [3:0]           ireq_requestor,
  output logic                      ireq_ready,
  output logic                      iresp_valid,
  output logic [31:0]               iresp_data,
  output logic [6:0]                iresp_ecc,
  output logic                      iresp_fault,
  // Instruction memory pins
  output logic [23:2]               imem_word_addr,
  output logic                      imem_select,
  output logic                      imem_privileged,
  output logic                      imem_write_en,
  output logic [4:0]                imem_byte_strobe,
  output logic [38:0]               imem_wr_word,
  output logic [3:0]                imem_requestor,
  input  wire logic [38:0]          imem_rd_word,
  input  wire logic                 imem_stall,
  input  wire logic                 imem_fault,
  // Data user side, one entry per port
  input  wire logic [NPORT-1:0]     dreq_valid,
  input  wire logic [NPORT*24-1:0]  dreq_addr,
  input  wire logic [NPORT-1:0]     dreq_priv,
  input  wire logic [NPORT-1:0]     dreq_write,
  input  wire logic [NPORT*5-1:0]   dreq_strobe,
  input  wire logic [NPORT*39-1:0]  dreq_wdata,
  input  wire logic [NPORT*4-1:0]   dreq_requestor,
  output logic [NPORT-1:0]          dreq_ready,
  output logic [NPORT-1:0]          dresp_valid,
  output logic [NPORT*32-1:0]       dresp_data,
  output logic [NPORT*7-1:0]        dresp_ecc,
  output logic [NPORT-1:0]          dresp_fault,
  // Data memory pins
  output logic [NPORT*20-1:0]       dmem_word_addr,
  output logic [NPORT-1:0]          dmem_select,
  output logic [NPORT-1:0]          dmem_privileged,
  output logic [NPORT-1:0]          dmem_write_en,
  output logic [NPORT*5-1:0]        dmem_byte_strobe,
  output logic [NPORT*39-1:0]       dmem_wr_word,
  output logic [NPORT*4-1:0]        dmem_requestor,
  input  wire logic [NPORT*39-1:0]  dmem_rd_word,
  input  wire logic [NPORT-1:0]     dmem_stall,
  input  wire logic [NPORT-1:0]     dmem_fault
);

  // One channel's state; the same layout serves the instruction and data ports.
  typedef struct packed {
    tcm_port_pkg::phase_type phase;
    logic [23:0]             addr;
    logic                    sel;
    logic                    priv;
    logic                    wr;
    logic [4:0]              strobe;
    logic [38:0]             wdata;
    logic [3:0]              req;
    logic                    ready;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [6:0]              recc;
    logic                    rfault;
  } chan_type;

  typedef struct packed {
    logic [1:0]              rst_sync;
    chan_type [NPORT:0]      ch;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic      rst_n;

  // The synchroniser output clears the channels synchronously, so that release is glitch free.
  assign rst_n = state_reg.rst_sync[1];

  // Channel 0 is the instruction port; channels 1 to NPORT are the data ports.
  logic [NPORT:0]       c_valid;
  logic [NPORT:0][23:0] c_addr;
  logic [NPORT:0]       c_priv;
  logic [NPORT:0]       c_write;
  logic [NPORT:0][4:0]  c_strobe;
  logic [NPORT:0][38:0] c_wdata;
  logic [NPORT:0][3:0]  c_req;
  logic [NPORT:0][38:0] c_rd;
  logic [NPORT:0]       c_stall;
  logic [NPORT:0]       c_fault;

  assign c_valid[0]  = ireq_valid;
  assign c_addr[0]   = ireq_addr;
  assign c_priv[0]   = ireq_priv;
  assign c_write[0]  = ireq_write;
  assign c_strobe[0] = ireq_strobe;
  assign c_wdata[0]  = ireq_wdata;
  assign c_req[0]    = ireq_requestor;
  assign c_rd[0]     = imem_rd_word;
  assign c_stall[0]  = imem_stall;
  assign c_fault[0]  = imem_fault;

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_dmap
      assign c_valid[g+1]  = dreq_valid[g];
      assign c_addr[g+1]   = dreq_addr[g*24 +: 24];
      assign c_priv[g+1]   = dreq_priv[g];
      assign c_write[g+1]  = dreq_write[g];
      // Data ports never strobe on a read.
      assign c_strobe[g+1] = dreq_write[g] ? dreq_strobe[g*5 +: 5]
                                           : tcm_port_pkg::STROBE_NONE;
      assign c_wdata[g+1]  = dreq_wdata[g*39 +: 39];
      assign c_req[g+1]    = dreq_requestor[g*4 +: 4];
      assign c_rd[g+1]     = dmem_rd_word[g*39 +: 39];
      assign c_stall[g+1]  = dmem_stall[g];
      assign c_fault[g+1]  = dmem_fault[g];

      assign dreq_ready[g]              = state_reg.ch[g+1].ready;
      assign dresp_valid[g]             = state_reg.ch[g+1].rvalid;
      assign dresp_data[g*32 +: 32]     = state_reg.ch[g+1].rdata;
      assign dresp_ecc[g*7 +: 7]        = state_reg.ch[g+1].recc;
      assign dresp_fault[g]             = state_reg.ch[g+1].rfault;
      assign dmem_word_addr[g*20 +: 20] = state_reg.ch[g+1].addr[23:4];
      assign dmem_select[g]             = state_reg.ch[g+1].sel;
      assign dmem_privileged[g]         = state_reg.ch[g+1].priv;
      assign dmem_write_en[g]           = state_reg.ch[g+1].wr;
      assign dmem_byte_strobe[g*5 +: 5] = state_reg.ch[g+1].strobe;
      assign dmem_wr_word[g*39 +: 39]   = state_reg.ch[g+1].wdata;
      assign dmem_requestor[g*4 +: 4]   = state_reg.ch[g+1].req;
    end
  endgenerate

  assign ireq_ready       = state_reg.ch[0].ready;
  assign iresp_valid      = state_reg.ch[0].rvalid;
  assign iresp_data       = state_reg.ch[0].rdata;
  assign iresp_ecc        = state_reg.ch[0].recc;
  assign iresp_fault      = state_reg.ch[0].rfault;
  assign imem_word_addr   = state_reg.ch[0].addr[23:2];
  assign imem_select      = state_reg.ch[0].sel;
  assign imem_privileged  = state_reg.ch[0].priv;
  assign imem_write_en    = state_reg.ch[0].wr;
  assign imem_byte_strobe = state_reg.ch[0].strobe;
  assign imem_wr_word     = state_reg.ch[0].wdata;
  assign imem_requestor   = state_reg.ch[0].req;

  always_comb begin
    state_next          = state_reg;
    state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
    for (int i = 0; i <= NPORT; i++) begin
      state_next.ch[i].rvalid = 1'b0;
      unique case (state_reg.ch[i].phase)
        tcm_port_pkg::ST_IDLE: begin
          state_next.ch[i].ready = 1'b1;
          state_next.ch[i].sel   = 1'b0;
          if (c_valid[i] && state_reg.ch[i].ready) begin
            // Address phase: every field goes out together with select.
            state_next.ch[i].phase  = tcm_port_pkg::ST_RESP;
            state_next.ch[i].sel    = 1'b1;
            state_next.ch[i].addr   = c_addr[i];
            state_next.ch[i].priv   = c_priv[i];
            state_next.ch[i].wr     = c_write[i];
            state_next.ch[i].strobe = c_strobe[i];
            state_next.ch[i].wdata  = c_wdata[i];
            state_next.ch[i].req    = c_req[i];
            state_next.ch[i].ready  = 1'b0;
          end
        end
        tcm_port_pkg::ST_RESP: begin
          // Select lasts one cycle; the memory ignores the rest while it is low.
          state_next.ch[i].sel    = 1'b0;
          state_next.ch[i].strobe = tcm_port_pkg::STROBE_NONE;
          state_next.ch[i].ready  = 1'b0;
          if (!c_stall[i]) begin
            state_next.ch[i].phase  = tcm_port_pkg::ST_IDLE;
            state_next.ch[i].rvalid = 1'b1;
            state_next.ch[i].rfault = c_fault[i];
            state_next.ch[i].recc   = c_rd[i][38:32];
            state_next.ch[i].rdata  = 32'h0000_0000;
            if (state_reg.ch[i].wr) begin
              state_next.ch[i].rdata = 32'h0000_0000;
            end else if (i == 0) begin
              state_next.ch[i].rdata = c_rd[i][31:0];
            end else begin
              // Data ports return the word shifted so the addressed byte sits low.
              state_next.ch[i].rdata = c_rd[i][31:0] >> {state_reg.ch[i].addr[1:0], 3'h0};
            end
          end
        end
        default: begin
          state_next.ch[i].phase = tcm_port_pkg::ST_IDLE;
        end
      endcase
    end
    // Channels stay cleared until the internal reset copy is released.
    if (!rst_n) begin
      state_next.ch = '0;
    end
  end

  // An unused data port sees all inputs low, so its stall never holds it.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// [tb/tcm_port_assertions.sv]
/*
  Timing checks on the local memory master port, bound into the top module.
  Assumes the memory pins and the user side share mclk.
*/
`timescale 1ns/1ps
module tcm_port_assertions #(
  parameter int NPORT = 4
) (
  input wire logic                mclk,
  input wire logic                nrst,
  input wire logic                ireq_valid,
  input wire logic                ireq_ready,
  input wire logic [23:0]         ireq_addr,
  input wire logic                ireq_priv,
  input wire logic [3:0]          ireq_requestor,
  input wire logic                imem_privileged,
  input wire logic [3:0]          imem_requestor,
  input wire logic                iresp_valid,
  input wire logic                iresp_fault,
  input wire logic                imem_select,
  input wire logic [23:2]         imem_word_addr,
  input wire logic                imem_stall,
  input wire logic                imem_fault,
  input wire logic [NPORT-1:0]    dreq_valid,
  input wire logic [NPORT-1:0]    dreq_ready,
  input wire logic [NPORT*24-1:0] dreq_addr,
  input wire logic [NPORT-1:0]    dreq_priv,
  input wire logic [NPORT-1:0]    dreq_write,
  input wire logic [NPORT*4-1:0]  dreq_requestor,
  input wire logic [NPORT-1:0]    dmem_select,
  input wire logic [NPORT-1:0]    dmem_write_en,
  input wire logic [NPORT*5-1:0]  dmem_byte_strobe,
  input wire logic [NPORT*20-1:0] dmem_word_addr,
  input wire logic [NPORT-1:0]    dmem_privileged,
  input wire logic [NPORT*4-1:0]  dmem_requestor
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  dstrb_read_a: assert property (!dmem_write_en[0] |-> dmem_byte_strobe[4:0] == 5'h00)
    else $error("data strobes set on a read");
  isel_pulse_a: assert property (imem_select |=> !imem_select)
    else $error("select held longer than one cycle");
  ibusy_a: assert property (imem_select |-> !ireq_ready)
    else $error("ready while a response is pending");
  iresp_time_a: assert property (imem_select && !imem_stall |=> iresp_valid)
    else $error("response missing after stall low");
  istall_a: assert property (imem_stall && !ireq_ready |=> !iresp_valid)
    else $error("response ended while stall high");
  ifault_a: assert property (iresp_valid |-> iresp_fault == $past(imem_fault))
    else $error("fault not taken from last cycle");
  iaddr_a: assert property (ireq_valid && ireq_ready |=>
    imem_select && imem_word_addr == $past(ireq_addr[23:2]))
    else $error("instruction address phase wrong");
  ifields_a: assert property (ireq_valid && ireq_ready |=> imem_privileged == $past(ireq_priv)
    && imem_requestor == $past(ireq_requestor))
    else $error("instruction privilege or requestor wrong");
  dfields_a: assert property (dreq_valid[0] && dreq_ready[0] |=> dmem_select[0] &&
    dmem_word_addr[19:0] == $past(dreq_addr[23:4]) && dmem_privileged[0] == $past(dreq_priv[0])
    && dmem_write_en[0] == $past(dreq_write[0]) && dmem_requestor[3:0] == $past(dreq_requestor[3:0]))
    else $error("data address phase wrong");
endmodule
bind tightly_coupled_memory_port tcm_port_assertions #(.NPORT(NPORT)) i_tcm_port_assertions (.*);

// [tb/tcm_bank_model.sv]
/*
  Behavioural local memory bank of sixteen words with set stall and fault.
  Assumes select, write enable, strobes and word come on the shared clock.
*/
`timescale 1ns/1ps
module tcm_bank_model (
  // Memory pins
  input  wire logic        clk,
  input  wire logic        sel,
  input  wire logic        we,
  input  wire logic [3:0]  addr,
  input  wire logic [4:0]  strb,
  input  wire logic [38:0] wd,
  output logic      [38:0] rd,
  output logic             stall,
  output logic             fault,
  // Test control
  input  wire logic [1:0]  wait_len,
  input  wire logic        fail
);
  logic [38:0] mem [16] = '{default: 39'h0};
  logic [3:0]  a_q = 4'h0;
  logic [1:0]  cnt = 2'h0;
  logic        act = 1'b0;
  logic        junk = 1'b0;
  logic [1:0]  left;
  logic        last;
  assign left  = sel ? wait_len : cnt;
  assign last  = (sel || act) && left == 2'h0;
  // Stall stays low outside a response, so an idle bank's stall looks like a tied-low input.
  assign stall = (sel || act) && !last;
  // Word and fault toggle off the last cycle, so early sampling is caught.
  assign fault = last ? fail : junk;
  assign rd    = last ? mem[sel ? addr : a_q] : {39{junk}};
  always @(posedge clk) begin
    junk <= ~junk;
    if (sel) begin
      a_q <= addr;
      act <= wait_len != 2'h0;
      cnt <= wait_len - 2'h1;
      if (we) begin
        for (int b = 0; b < 4; b++)
          if (strb[b]) mem[addr][8*b +: 8] <= wd[8*b +: 8];
        if (strb[4]) mem[addr][38:32] <= wd[38:32];
      end
    end else if (act) begin
      if (cnt == 2'h0) act <= 1'b0;
      else cnt <= cnt - 2'h1;
    end
  end
endmodule

// [tb/tightly_coupled_memory_port_tb.sv]
/*
  Random traffic over all five channels against bank models and a shadow memory.
  Channel 4 is the instruction port, channels 0 to 3 the data ports.
*/
`timescale 1ns/1ps
module tightly_coupled_memory_port_tb;
  localparam logic [3:0] CODES [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'hB, 4'hC,
                                        4'hD, 4'hE};
  logic         mclk = 1'b0;
  logic         nrst = 1'b0;
  logic [4:0]   vv = '0, pv = '0, wv = '0, fl = '0, rdy, rv, rf, sel, we, stl, flt;
  logic [119:0] av = '0;
  logic [24:0]  sv = '0, sb;
  logic [194:0] dv = '0, wdw, rdw;
  logic [19:0]  qv = '0;
  logic [159:0] rdat;
  logic [34:0]  recc;
  logic [101:0] wa;
  logic [1:0]   wl [5] = '{default: 2'h0};
  logic [40:0]  e, exp_q [5][$];
  logic [38:0]  v, shd [5][16] = '{default: 39'h0};
  int           err_count = 0, check_count = 0;
  tightly_coupled_memory_port i_tightly_coupled_memory_port (.mclk(mclk), .nrst(nrst),
    .ireq_valid(vv[4]), .ireq_addr(av[119:96]), .ireq_priv(pv[4]), .ireq_write(wv[4]),
    .ireq_strobe(sv[24:20]), .ireq_wdata(dv[194:156]), .ireq_requestor(qv[19:16]),
    .ireq_ready(rdy[4]), .iresp_valid(rv[4]), .iresp_data(rdat[159:128]),
    .iresp_ecc(recc[34:28]), .iresp_fault(rf[4]), .imem_word_addr(wa[101:80]),
    .imem_select(sel[4]), .imem_privileged(), .imem_write_en(we[4]),
    .imem_byte_strobe(sb[24:20]), .imem_wr_word(wdw[194:156]), .imem_requestor(),
    .imem_rd_word(rdw[194:156]), .imem_stall(stl[4]), .imem_fault(flt[4]),
    .dreq_valid(vv[3:0]), .dreq_addr(av[95:0]), .dreq_priv(pv[3:0]), .dreq_write(wv[3:0]),
    .dreq_strobe(sv[19:0]), .dreq_wdata(dv[155:0]), .dreq_requestor(qv[15:0]),
    .dreq_ready(rdy[3:0]), .dresp_valid(rv[3:0]), .dresp_data(rdat[127:0]),
    .dresp_ecc(recc[27:0]), .dresp_fault(rf[3:0]), .dmem_word_addr(wa[79:0]),
    .dmem_select(sel[3:0]), .dmem_privileged(), .dmem_write_en(we[3:0]),
    .dmem_byte_strobe(sb[19:0]), .dmem_wr_word(wdw[155:0]), .dmem_requestor(),
    .dmem_rd_word(rdw[155:0]), .dmem_stall(stl[3:0]), .dmem_fault(flt[3:0]));
  for (genvar g = 0; g < 5; g++) begin : g_bank
    tcm_bank_model i_tcm_bank_model (.clk(mclk), .sel(sel[g]), .we(we[g]),
      .addr(wa[20*g +: 4]), .strb(sb[5*g +: 5]), .wd(wdw[39*g +: 39]), .rd(rdw[39*g +: 39]),
      .stall(stl[g]), .fault(flt[g]), .wait_len(wl[g]), .fail(fl[g]));
  end
  task check(string name, logic [40:0] seen, logic [40:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task end_of_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Static task: one caller only, so its locals may sit on the left of non-blocking writes.
  task issue(int g, logic [3:0] code);
    logic [23:0] a;
    logic [38:0] d;
    logic [4:0]  s;
    logic        w, f;
    int          x, n;
    a = 24'($urandom);
    d = 39'({$urandom, $urandom});
    w = 1'($urandom);
    s = w ? 5'($urandom) : 5'h00;
    f = $urandom_range(3) == 0;
    x = g == 4 ? a[5:2] : a[7:4];
    if (w) begin
      for (int b = 0; b < 4; b++)
        if (s[b]) shd[g][x][8*b +: 8] = d[8*b +: 8];
      if (s[4]) shd[g][x][38:32] = d[38:32];
      exp_q[g].push_back({1'b0, f, 39'h0});
    end else begin
      v = shd[g][x];
      exp_q[g].push_back({1'b1, f, v[38:32], g == 4 ? v[31:0] : v[31:0] >> (8 * a[1:0])});
    end
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rdy[g] !== 1'b1 && n < 50);
    vv[g] <= 1'b1;
    av[24*g +: 24] <= a;
    pv[g] <= 1'($urandom);
    wv[g] <= w;
    sv[5*g +: 5] <= s;
    dv[39*g +: 39] <= d;
    qv[4*g +: 4] <= code;
    wl[g] <= 2'($urandom);
    fl[g] <= f;
    do @(posedge mclk); while (rdy[g] !== 1'b1);
    vv[g] <= 1'b0;
  endtask
  always @(posedge mclk)
    for (int g = 0; g < 5; g++)
      if (rv[g] === 1'b1) begin
        e = exp_q[g].size() > 0 ? exp_q[g].pop_front() : 41'h0;
        check("response", {e[40], rf[g], e[40] ? recc[7*g +: 7] : 7'h0, rdat[32*g +: 32]}, e);
      end
  initial forever #5 mclk = ~mclk;
  initial begin
    #200000;
    err_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h08e2c487));
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    for (int i = 0; i < 110; i++) issue($urandom_range(4), CODES[i % 11]);
    repeat (20) @(posedge mclk);
    for (int g = 0; g < 5; g++) check("pending", 41'(exp_q[g].size()), 41'h0);
    end_of_test();
  end
endmodule
